// ===== psm_cfg.svh
// Power-save controller constants: offsets, fields, reset values, timing
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// APB register byte offsets
`define PSM_OFF_CTRL 8'h00
`define PSM_OFF_WAKE 8'h04
`define PSM_OFF_SCR0 8'h08
`define PSM_OFF_SCR1 8'h0C
`define PSM_OFF_CFG 8'h10
`define PSM_OFF_STAT 8'h14
`define PSM_OFF_CLK 8'h18

// Control register fields
`define PSM_CTRL_ARM 15
`define PSM_CTRL_BOR 1
`define PSM_CTRL_REL 0

// Configuration register fields
`define PSM_CFG_WDT 0
`define PSM_CFG_CAL 1
`define PSM_CFG_CALLP 2
`define PSM_CFG_CLOCK_FAIL_MONITOR 3
`define PSM_CFG_DEEP_SLEEP_WATCHDOG 4
`define PSM_CFG_DEEP_SLEEP_BROWNOUT 5
`define PSM_CFG_EXTERNAL_INTERRUPT_ZERO 6
`define PSM_CFG_MASK_LO 8
`define PSM_CFG_RST 16'h0000
`define PSM_CFG_KEEP 16'h0076

// Wake-source register fields
`define PSM_WK_POR 0
`define PSM_WK_MASTER_CLEAR_PIN 1
`define PSM_WK_CAL 2
`define PSM_WK_EXTERNAL_INTERRUPT_ZERO 3
`define PSM_WK_DEEP_SLEEP_WATCHDOG 4
`define PSM_WK_DEEP_SLEEP_BROWNOUT 5
`define PSM_WK_W 6

// Status register fields
`define PSM_STAT_EXIT 4
`define PSM_STAT_ST_W 3

// Widths and reset values
`define PSM_NPERIPH 8
`define PSM_CLK_W 3
`define PSM_CLK_RST 3'h0
`define PSM_SCR_W 16
`define PSM_CNT_W 4

// Arm window: instruction cycles and clocks per instruction cycle
`define PSM_ARM_WIN_TCY 3
`define PSM_CLK_PER_TCY 2
`define PSM_ARM_WIN_CLKS (`PSM_ARM_WIN_TCY * `PSM_CLK_PER_TCY)

// Power-save request mode selector
`define PSM_MODE_SLEEP 1'b0
`define PSM_MODE_IDLE 1'b1

`endif

// ===== psm_pkg.sv
// Power-save controller types
`include "psm_cfg.svh"
package psm_pkg;

  typedef enum logic [2:0] {
    PSM_RUN,
    PSM_ENTER,
    PSM_SLEEP,
    PSM_IDLE,
    PSM_DEEP,
    PSM_DSPOR
  } psm_state_t;

  typedef struct packed {
    psm_state_t st;
    logic arm;
    logic release_io;
    logic bor_flag;
    logic [`PSM_WK_W-1:0] wake;
    logic [`PSM_SCR_W-1:0] scr0;
    logic [`PSM_SCR_W-1:0] scr1;
    logic [15:0] cfg;
    logic [`PSM_CLK_W-1:0] clk_sel;
    logic [`PSM_CLK_W-1:0] clk_saved;
    logic ds_exited;
    logic [`PSM_CNT_W-1:0] arm_cnt;
    logic held_irq;
    logic mode_idle;
    logic cpu_clk_en;
    logic sys_clk_en;
    logic osc_en;
    logic [`PSM_NPERIPH-1:0] periph_en;
    logic low_power_rc_oscillator_en;
    logic clock_fail_monitor_en;
    logic wdt_clr;
    logic io_freeze;
    logic mem_pwr_en;
    logic irq_discard;
    logic cpu_resume;
    logic ds_por_req;
    logic cal_clk_en;
    logic deep_sleep_watchdog_run;
    logic deep_sleep_brownout_run;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } psm_regs_t;

endpackage

// ===== psm_ctrl.sv
// Power-save mode controller with APB register slave
`timescale 1ns/10ps
`default_nettype none
`include "psm_cfg.svh"

module psm_ctrl
  import psm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic PSAV_REQ,
  input wire logic PSAV_MODE,
  input wire logic IRQ_PEND,
  input wire logic WDT_TIMEOUT,
  input wire logic RESET_REQ,
  input wire logic POR_EVT,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic CAL_ALARM,
  input wire logic EXT_EXTERNAL_INTERRUPT_ZERO,
  input wire logic DEEP_SLEEP_WATCHDOG_TIMEOUT,
  input wire logic DEEP_SLEEP_BROWNOUT_TRIP,
  input wire logic POR_DONE,
  output logic CPU_CLK_EN,
  output logic SYS_CLK_EN,
  output logic OSC_EN,
  output logic [`PSM_NPERIPH-1:0] PERIPH_CLK_EN,
  output logic LOW_POWER_RC_OSCILLATOR_EN,
  output logic CLOCK_FAIL_MONITOR_EN,
  output logic WDT_CLR,
  output logic IO_FREEZE,
  output logic MEM_PWR_EN,
  output logic IRQ_DISCARD,
  output logic CPU_RESUME,
  output logic DS_POR_REQ,
  output logic [`PSM_CLK_W-1:0] CLK_SEL,
  output logic CAL_CLK_EN,
  output logic DEEP_SLEEP_WATCHDOG_RUN,
  output logic DEEP_SLEEP_BROWNOUT_RUN
);

  logic rst_meta_r;
  logic rst_n;
  psm_regs_t r;
  psm_regs_t n;
  logic wr_en;
  logic rd_en;
  logic deep_sel;
  logic sw_wake;
  logic [`PSM_WK_W-1:0] ds_wake;
  logic [31:0] rd_data;
  logic rd_hit;

  // Reset release synchroniser
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Bus strobes and wake decode
  assign wr_en = PSEL & PENABLE & r.pready & PWRITE;
  assign rd_en = PSEL & PENABLE & ~r.pready;
  assign deep_sel = (PSAV_MODE == `PSM_MODE_SLEEP) & r.arm;
  assign sw_wake = IRQ_PEND | WDT_TIMEOUT | RESET_REQ | r.held_irq;
  // Deep Sleep wake sources; POR and master clear ungated, the rest gated by their enables
  assign ds_wake[`PSM_WK_POR] = POR_EVT;
  assign ds_wake[`PSM_WK_MASTER_CLEAR_PIN] = ~MASTER_CLEAR_PIN_N;
  assign ds_wake[`PSM_WK_CAL] = CAL_ALARM & r.cfg[`PSM_CFG_CAL];
  assign ds_wake[`PSM_WK_EXTERNAL_INTERRUPT_ZERO] = EXT_EXTERNAL_INTERRUPT_ZERO & r.cfg[`PSM_CFG_EXTERNAL_INTERRUPT_ZERO];
  assign ds_wake[`PSM_WK_DEEP_SLEEP_WATCHDOG] = DEEP_SLEEP_WATCHDOG_TIMEOUT & r.cfg[`PSM_CFG_DEEP_SLEEP_WATCHDOG];
  assign ds_wake[`PSM_WK_DEEP_SLEEP_BROWNOUT] = DEEP_SLEEP_BROWNOUT_TRIP & r.cfg[`PSM_CFG_DEEP_SLEEP_BROWNOUT];

  // Read data mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
      `PSM_OFF_CTRL: begin
        rd_data[`PSM_CTRL_ARM] = r.arm;
        rd_data[`PSM_CTRL_BOR] = r.bor_flag;
        rd_data[`PSM_CTRL_REL] = r.release_io;
      end
      `PSM_OFF_WAKE: rd_data[`PSM_WK_W-1:0] = r.wake;
      `PSM_OFF_SCR0: rd_data[`PSM_SCR_W-1:0] = r.scr0;
      `PSM_OFF_SCR1: rd_data[`PSM_SCR_W-1:0] = r.scr1;
      `PSM_OFF_CFG: rd_data[15:0] = r.cfg;
      `PSM_OFF_STAT: begin
        rd_data[`PSM_STAT_ST_W-1:0] = r.st;
        rd_data[`PSM_STAT_EXIT] = r.ds_exited;
      end
      `PSM_OFF_CLK: rd_data[`PSM_CLK_W-1:0] = r.clk_sel;
      default: rd_hit = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    n = r;
    n.wdt_clr = 1'b0;
    n.irq_discard = 1'b0;
    n.cpu_resume = 1'b0;
    // APB slave: one wait state, answer registered
    n.pready = rd_en;
    n.pslverr = 1'b0; // Error flag stands with ready only
    if (rd_en) begin
      n.prdata = PWRITE ? 32'h0000_0000 : rd_data;
      n.pslverr = ~rd_hit;
    end
    if (wr_en && rd_hit) begin
      case (PADDR)
        `PSM_OFF_CTRL: begin
          if (PWDATA[`PSM_CTRL_ARM] && !r.arm) begin
            n.arm = 1'b1;
            n.arm_cnt = `PSM_CNT_W'(`PSM_ARM_WIN_CLKS);
            n.wake = '0;
          end else if (!PWDATA[`PSM_CTRL_ARM]) begin
            n.arm = 1'b0;
          end
          if (!PWDATA[`PSM_CTRL_REL]) begin
            n.release_io = 1'b0;
          end
          if (!PWDATA[`PSM_CTRL_BOR]) begin
            n.bor_flag = 1'b0;
          end
        end
        `PSM_OFF_SCR0: n.scr0 = PWDATA[`PSM_SCR_W-1:0];
        `PSM_OFF_SCR1: n.scr1 = PWDATA[`PSM_SCR_W-1:0];
        `PSM_OFF_CFG: n.cfg = PWDATA[15:0];
        `PSM_OFF_STAT: begin
          if (PWDATA[`PSM_STAT_EXIT]) begin
            n.ds_exited = 1'b0;
          end
        end
        `PSM_OFF_CLK: n.clk_sel = PWDATA[`PSM_CLK_W-1:0];
        default: n.pslverr = r.pslverr;
      endcase
    end
    // Power-mode sequencing
    case (r.st)
      PSM_RUN: begin
        if (r.arm && r.arm_cnt != '0) begin
          n.arm_cnt = r.arm_cnt - `PSM_CNT_W'(1);
        end
        if (PSAV_REQ && deep_sel) begin
          n.st = PSM_DEEP;
          n.irq_discard = 1'b1;
          n.release_io = 1'b1;
        end else if (PSAV_REQ) begin
          n.st = PSM_ENTER;
          n.mode_idle = (PSAV_MODE == `PSM_MODE_IDLE);
          n.clk_saved = r.clk_sel;
          n.wdt_clr = r.cfg[`PSM_CFG_WDT];
          n.held_irq = 1'b0;
        end else if (r.arm && r.arm_cnt == '0) begin
          n.arm = 1'b0;
        end
      end
      PSM_ENTER: begin
        n.held_irq = IRQ_PEND;
        n.st = r.mode_idle ? PSM_IDLE : PSM_SLEEP;
      end
      PSM_SLEEP, PSM_IDLE: begin
        if (sw_wake) begin
          n.st = PSM_RUN;
          n.cpu_resume = 1'b1;
          n.held_irq = 1'b0;
          n.clk_sel = r.clk_saved;
        end
      end
      PSM_DEEP: begin
        if (DEEP_SLEEP_BROWNOUT_TRIP && r.cfg[`PSM_CFG_DEEP_SLEEP_BROWNOUT]) begin
          n.bor_flag = 1'b1;
        end
        if (ds_wake != '0) begin
          n.st = PSM_DSPOR;
          n.wake = r.wake | ds_wake;
          n.arm = 1'b0;
          n.arm_cnt = '0;
          // Retained: scratch, wake flags, calendar, deep watchdog, deep brownout and INT0 setup
          n.cfg = r.cfg & `PSM_CFG_KEEP;
          n.clk_sel = `PSM_CLK_RST;
        end
      end
      PSM_DSPOR: begin
        if (POR_DONE) begin
          n.st = PSM_RUN;
          n.ds_exited = 1'b1;
        end
      end
      default: n.st = PSM_RUN;
    endcase
    // Registered power outputs from the next state
    n.cpu_clk_en = (n.st == PSM_RUN);
    n.sys_clk_en = (n.st == PSM_RUN) || (n.st == PSM_ENTER) || (n.st == PSM_IDLE);
    n.osc_en = n.sys_clk_en;
    n.periph_en = '0;
    if (n.st == PSM_IDLE) begin
      n.periph_en = ~n.cfg[`PSM_CFG_MASK_LO +: `PSM_NPERIPH];
    end else if (n.st == PSM_RUN || n.st == PSM_ENTER) begin
      n.periph_en = '1;
    end
    n.clock_fail_monitor_en = n.cfg[`PSM_CFG_CLOCK_FAIL_MONITOR] && n.sys_clk_en;
    case (n.st)
      PSM_SLEEP: n.low_power_rc_oscillator_en = n.cfg[`PSM_CFG_WDT] ||
                   (n.cfg[`PSM_CFG_CAL] && n.cfg[`PSM_CFG_CALLP]);
      PSM_DEEP: n.low_power_rc_oscillator_en = n.cfg[`PSM_CFG_DEEP_SLEEP_WATCHDOG] ||
                  (n.cfg[`PSM_CFG_CAL] && n.cfg[`PSM_CFG_CALLP]);
      default: n.low_power_rc_oscillator_en = n.cfg[`PSM_CFG_WDT] || n.cfg[`PSM_CFG_CLOCK_FAIL_MONITOR] ||
                 (n.cfg[`PSM_CFG_CAL] && n.cfg[`PSM_CFG_CALLP]);
    endcase
    n.io_freeze = (n.st == PSM_SLEEP) || (n.st == PSM_DEEP) || n.release_io;
    n.mem_pwr_en = (n.st != PSM_DEEP);
    n.ds_por_req = (n.st == PSM_DSPOR);
    n.cal_clk_en = n.cfg[`PSM_CFG_CAL];
    n.deep_sleep_watchdog_run = (n.st == PSM_DEEP) && n.cfg[`PSM_CFG_DEEP_SLEEP_WATCHDOG];
    n.deep_sleep_brownout_run = (n.st == PSM_DEEP) && n.cfg[`PSM_CFG_DEEP_SLEEP_BROWNOUT];
  end

  // State register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= PSM_RUN;
      r.cfg <= `PSM_CFG_RST;
      r.clk_sel <= `PSM_CLK_RST;
      r.cpu_clk_en <= 1'b1;
      r.sys_clk_en <= 1'b1;
      r.osc_en <= 1'b1;
      r.periph_en <= '1;
      r.mem_pwr_en <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign PREADY = r.pready;
  assign PRDATA = r.prdata;
  assign PSLVERR = r.pslverr;
  assign CPU_CLK_EN = r.cpu_clk_en;
  assign SYS_CLK_EN = r.sys_clk_en;
  assign OSC_EN = r.osc_en;
  assign PERIPH_CLK_EN = r.periph_en;
  assign LOW_POWER_RC_OSCILLATOR_EN = r.low_power_rc_oscillator_en;
  assign CLOCK_FAIL_MONITOR_EN = r.clock_fail_monitor_en;
  assign WDT_CLR = r.wdt_clr;
  assign IO_FREEZE = r.io_freeze;
  assign MEM_PWR_EN = r.mem_pwr_en;
  assign IRQ_DISCARD = r.irq_discard;
  assign CPU_RESUME = r.cpu_resume;
  assign DS_POR_REQ = r.ds_por_req;
  assign CLK_SEL = r.clk_sel;
  assign CAL_CLK_EN = r.cal_clk_en;
  assign DEEP_SLEEP_WATCHDOG_RUN = r.deep_sleep_watchdog_run;
  assign DEEP_SLEEP_BROWNOUT_RUN = r.deep_sleep_brownout_run;

  // Checks on the sequencing
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence plain_entry_s;
    r.st == PSM_RUN && PSAV_REQ && !deep_sel;
  endsequence

  sequence sleep_entry_s;
    r.st == PSM_RUN && PSAV_REQ && PSAV_MODE == `PSM_MODE_SLEEP && !r.arm;
  endsequence

  sequence deep_entry_s;
    r.st == PSM_RUN && PSAV_REQ && deep_sel;
  endsequence

  wdt_entry_clear_a: assert property (
    plain_entry_s ##0 r.cfg[`PSM_CFG_WDT] |=> WDT_CLR ##1 !WDT_CLR)
    else $error("watchdog not cleared on power-save entry");

  sleep_clocks_a: assert property (
    r.st == PSM_SLEEP |-> !SYS_CLK_EN && !OSC_EN && !CPU_CLK_EN && PERIPH_CLK_EN == '0)
    else $error("clocks running in sleep");

  idle_clocks_a: assert property (
    r.st == PSM_IDLE |-> SYS_CLK_EN && !CPU_CLK_EN)
    else $error("idle clock gating wrong");

  sleep_quiet_a: assert property (
    r.st == PSM_SLEEP |-> !CLOCK_FAIL_MONITOR_EN && IO_FREEZE)
    else $error("monitor or pins active in sleep");

  held_wake_a: assert property (
    sleep_entry_s ##1 IRQ_PEND |=> r.st == PSM_SLEEP ##1 r.st == PSM_RUN && CPU_RESUME)
    else $error("held interrupt did not wake");

  idle_wake_a: assert property (
    r.st == PSM_IDLE && IRQ_PEND |=> r.st == PSM_RUN && CPU_CLK_EN && CPU_RESUME)
    else $error("idle wake-up not immediate");

  arm_expire_a: assert property (
    r.st == PSM_RUN && r.arm && r.arm_cnt == '0 && !PSAV_REQ && !wr_en |=> !r.arm)
    else $error("arm bit outlived its window");

  deep_exit_a: assert property (
    r.st == PSM_DEEP && ds_wake != '0 |=> !r.arm && DS_POR_REQ ##1 r.wake != '0)
    else $error("deep exit left arm set");

  arm_clears_wake_a: assert property (
    $rose(r.arm) |-> r.wake == '0)
    else $error("wake flags survive arming");

  por_ignore_a: assert property (
    r.st == PSM_DSPOR |=> $stable(r.wake))
    else $error("wake recorded during POR sequence");

  release_hold_a: assert property (
    r.release_io && !(wr_en && PADDR == `PSM_OFF_CTRL) |=> r.release_io && IO_FREEZE)
    else $error("pins released before software");

  deep_entry_a: assert property (
    deep_entry_s |=> r.st == PSM_DEEP && IRQ_DISCARD && !MEM_PWR_EN && IO_FREEZE)
    else $error("deep entry did not discard and freeze");

  deep_quiet_a: assert property (
    r.st == PSM_DEEP |-> !CPU_CLK_EN && !SYS_CLK_EN && PERIPH_CLK_EN == '0 && !MEM_PWR_EN)
    else $error("clocks or memory powered in deep sleep");

  sleep_low_power_rc_oscillator_a: assert property (
    r.st == PSM_SLEEP && r.cfg[`PSM_CFG_WDT] |-> LOW_POWER_RC_OSCILLATOR_EN)
    else $error("low-power oscillator off in sleep");

  idle_low_power_rc_oscillator_a: assert property (
    r.st == PSM_IDLE && (r.cfg[`PSM_CFG_WDT] || r.cfg[`PSM_CFG_CLOCK_FAIL_MONITOR]) |-> LOW_POWER_RC_OSCILLATOR_EN)
    else $error("low-power oscillator off in idle");

  clock_restore_a: assert property (
    r.st == PSM_SLEEP && sw_wake |=> CLK_SEL == $past(r.clk_saved))
    else $error("clock source not restored after sleep");

endmodule
`default_nettype wire

// ===== psm_ctrl_tb.sv
// Self-checking bench for the power-save mode controller
`timescale 1ns/10ps
`default_nettype none
`include "psm_cfg.svh"
module psm_ctrl_tb;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic PSAV_REQ = 1'b0;
  logic PSAV_MODE = 1'b0;
  logic IRQ_PEND = 1'b0;
  logic WDT_TIMEOUT = 1'b0;
  logic RESET_REQ = 1'b0;
  logic POR_EVT = 1'b0;
  logic MASTER_CLEAR_PIN_N = 1'b1;
  logic CAL_ALARM = 1'b0;
  logic EXT_EXTERNAL_INTERRUPT_ZERO = 1'b0;
  logic DEEP_SLEEP_WATCHDOG_TIMEOUT = 1'b0;
  logic DEEP_SLEEP_BROWNOUT_TRIP = 1'b0;
  logic POR_DONE = 1'b0;
  logic PREADY, PSLVERR, CPU_CLK_EN, SYS_CLK_EN, OSC_EN, LOW_POWER_RC_OSCILLATOR_EN, CLOCK_FAIL_MONITOR_EN, WDT_CLR;
  logic IO_FREEZE, MEM_PWR_EN, IRQ_DISCARD, CPU_RESUME, DS_POR_REQ, CAL_CLK_EN;
  logic DEEP_SLEEP_WATCHDOG_RUN, DEEP_SLEEP_BROWNOUT_RUN;
  logic [31:0] PRDATA;
  logic [`PSM_NPERIPH-1:0] PERIPH_CLK_EN;
  logic [`PSM_CLK_W-1:0] CLK_SEL;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int tests_run = 0;
  int k;

  psm_ctrl i_psm_ctrl (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .PSAV_REQ(PSAV_REQ), .PSAV_MODE(PSAV_MODE), .IRQ_PEND(IRQ_PEND),
    .WDT_TIMEOUT(WDT_TIMEOUT), .RESET_REQ(RESET_REQ), .POR_EVT(POR_EVT), .MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N),
    .CAL_ALARM(CAL_ALARM), .EXT_EXTERNAL_INTERRUPT_ZERO(EXT_EXTERNAL_INTERRUPT_ZERO), .DEEP_SLEEP_WATCHDOG_TIMEOUT(DEEP_SLEEP_WATCHDOG_TIMEOUT),
    .DEEP_SLEEP_BROWNOUT_TRIP(DEEP_SLEEP_BROWNOUT_TRIP), .POR_DONE(POR_DONE), .CPU_CLK_EN(CPU_CLK_EN),
    .SYS_CLK_EN(SYS_CLK_EN), .OSC_EN(OSC_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .LOW_POWER_RC_OSCILLATOR_EN(LOW_POWER_RC_OSCILLATOR_EN), .CLOCK_FAIL_MONITOR_EN(CLOCK_FAIL_MONITOR_EN), .WDT_CLR(WDT_CLR), .IO_FREEZE(IO_FREEZE),
    .MEM_PWR_EN(MEM_PWR_EN), .IRQ_DISCARD(IRQ_DISCARD), .CPU_RESUME(CPU_RESUME),
    .DS_POR_REQ(DS_POR_REQ), .CLK_SEL(CLK_SEL), .CAL_CLK_EN(CAL_CLK_EN),
    .DEEP_SLEEP_WATCHDOG_RUN(DEEP_SLEEP_WATCHDOG_RUN), .DEEP_SLEEP_BROWNOUT_RUN(DEEP_SLEEP_BROWNOUT_RUN));

  // 25 MHz clock
  always #20 CLK = ~CLK;

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and stop
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20 && PREADY !== 1'b1; n++) @(posedge CLK);
    if (n == 20) begin
      bad_count++;
      end_of_test();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Read and compare a register
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  // Power-save request pulse; returns at the edge that takes it
  task automatic req(input logic mode);
    @(posedge CLK);
    PSAV_REQ <= 1'b1;
    PSAV_MODE <= mode;
    @(posedge CLK);
    PSAV_REQ <= 1'b0;
  endtask

  // Hang guard
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    #1 chk("rst cpu", CPU_CLK_EN, 1'b1);
    chk("rst mem", MEM_PWR_EN, 1'b1);
    repeat (3) @(posedge CLK);
    rdchk("cfg rst", `PSM_OFF_CFG, 32'h0);
    rdchk("clk rst", `PSM_OFF_CLK, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("bad err", er, 1'b1);
    chk("bad data", rd, 32'h0);
    $display("done: reset");
    // Idle with masked peripherals, woken by each source
    apb(1'b1, `PSM_OFF_CFG, 32'h0F09);
    for (k = 0; k < 3; k++) begin
      req(`PSM_MODE_IDLE);
      #1 chk("idle wclr", WDT_CLR, 1'b1);
      chk("idle cpu", CPU_CLK_EN, 1'b0);
      @(posedge CLK);
      #1 chk("idle sys", SYS_CLK_EN, 1'b1);
      chk("idle per", PERIPH_CLK_EN, 8'hF0);
      chk("idle low_power_rc_oscillator", LOW_POWER_RC_OSCILLATOR_EN, 1'b1);
      chk("idle clock_fail_monitor", CLOCK_FAIL_MONITOR_EN, 1'b1);
      chk("idle cpu2", CPU_CLK_EN, 1'b0);
      @(posedge CLK);
      {RESET_REQ, WDT_TIMEOUT, IRQ_PEND} <= 3'b001 << k;
      @(posedge CLK);
      {RESET_REQ, WDT_TIMEOUT, IRQ_PEND} <= 3'b000;
      #1 chk("idle wake", CPU_CLK_EN, 1'b1);
      chk("idle res", CPU_RESUME, 1'b1);
    end
    $display("done: idle");
    // Sleep with an interrupt during entry
    apb(1'b1, `PSM_OFF_CLK, 32'h5);
    req(`PSM_MODE_SLEEP);
    IRQ_PEND <= 1'b1;
    #1 chk("slp wclr", WDT_CLR, 1'b1);
    @(posedge CLK);
    IRQ_PEND <= 1'b0;
    #1 chk("slp sys", SYS_CLK_EN, 1'b0);
    chk("slp osc", OSC_EN, 1'b0);
    chk("slp frz", IO_FREEZE, 1'b1);
    chk("slp clock_fail_monitor", CLOCK_FAIL_MONITOR_EN, 1'b0);
    chk("slp low_power_rc_oscillator", LOW_POWER_RC_OSCILLATOR_EN, 1'b1);
    chk("slp per", PERIPH_CLK_EN, 8'h00);
    @(posedge CLK);
    #1 chk("slp held", CPU_RESUME, 1'b1);
    chk("slp clk", CLK_SEL, 3'h5);
    $display("done: sleep");
    // Deep Sleep entry, alarm wake, ignored late wake
    apb(1'b1, `PSM_OFF_SCR0, 32'hA5A5);
    apb(1'b1, `PSM_OFF_CFG, 32'h0033);
    apb(1'b1, `PSM_OFF_CTRL, 32'h8000);
    req(`PSM_MODE_SLEEP);
    #1 chk("ds mem", MEM_PWR_EN, 1'b0);
    chk("ds frz", IO_FREEZE, 1'b1);
    chk("ds disc", IRQ_DISCARD, 1'b1);
    chk("ds wdt", DEEP_SLEEP_WATCHDOG_RUN, 1'b1);
    chk("ds bor", DEEP_SLEEP_BROWNOUT_RUN, 1'b1);
    chk("ds cal", CAL_CLK_EN, 1'b1);
    chk("ds sys", SYS_CLK_EN, 1'b0);
    @(posedge CLK);
    CAL_ALARM <= 1'b1;
    @(posedge CLK);
    CAL_ALARM <= 1'b0;
    #1 chk("ds por", DS_POR_REQ, 1'b1);
    @(posedge CLK);
    MASTER_CLEAR_PIN_N <= 1'b0;
    @(posedge CLK);
    MASTER_CLEAR_PIN_N <= 1'b1;
    POR_DONE <= 1'b1;
    @(posedge CLK);
    POR_DONE <= 1'b0;
    #1 chk("ds run", CPU_CLK_EN, 1'b1);
    chk("ds hold", IO_FREEZE, 1'b1);
    rdchk("ds wake", `PSM_OFF_WAKE, 32'h04);
    rdchk("ds ctrl", `PSM_OFF_CTRL, 32'h01);
    rdchk("ds stat", `PSM_OFF_STAT, 32'h10);
    rdchk("ds cfg", `PSM_OFF_CFG, 32'h32);
    rdchk("ds clk", `PSM_OFF_CLK, 32'h0);
    rdchk("ds scr", `PSM_OFF_SCR0, 32'hA5A5);
    apb(1'b1, `PSM_OFF_CTRL, 32'h0);
    #1 chk("ds rel", IO_FREEZE, 1'b0);
    repeat (`PSM_ARM_WIN_CLKS) @(posedge CLK);
    $display("done: deep");
    // Arm lapses; late request gives plain Sleep
    apb(1'b1, `PSM_OFF_CTRL, 32'h8000);
    rdchk("arm wake", `PSM_OFF_WAKE, 32'h0);
    repeat (8) @(posedge CLK);
    rdchk("arm lapse", `PSM_OFF_CTRL, 32'h0);
    req(`PSM_MODE_SLEEP);
    @(posedge CLK);
    #1 chk("lapse mem", MEM_PWR_EN, 1'b1);
    chk("lapse sys", SYS_CLK_EN, 1'b0);
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b1;
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    #1 chk("lapse wake", CPU_CLK_EN, 1'b1);
    $display("done: arm window");
    end_of_test();
  end
endmodule
`default_nettype wire
